// File: csf_blink.v
// lamp flash timer: square wave with a one second period
// assumes a free-running clock at the rate given in the header
`timescale 1ns/1ps
`include "csf_defs.vh"

module csf_blink #(
  parameter [23:0] half_cycles = `CSF_HALF_CYCLES
) (
  clk,
  reset_n,
  restart,
  phase
);
  input  wire clk;
  input  wire reset_n;
  input  wire restart;
  output reg  phase;

  reg [23:0] count;

  // ****************************************
  // half period counter
  // ****************************************
  always @(posedge clk) begin
    if (!reset_n) begin
      count <= 24'h000000;
      phase <= 1'b1;
    end else if (restart) begin
      // the restart edge itself counts as the first cycle of the on phase
      count <= 24'h000001;
      phase <= 1'b1;
    end else if (count == half_cycles - 24'h000001) begin
      count <= 24'h000000;
      phase <= ~phase; // R13
    end else begin
      count <= count + 24'h000001;
    end
  end
endmodule

// File: csf_defs.vh
// constants for the charge session controller: register map, fields, timing
// assumes a 20 MHz system clock and a 32-bit avalon-mm slave
`ifndef CSF_DEFS_VH
`define CSF_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define CSF_REG_CTRL      4'h0
`define CSF_REG_STATUS    4'h4
`define CSF_REG_IRQ_STAT  4'h8
`define CSF_REG_IRQ_EN    4'hc

// ****************************************
// control fields
// ****************************************
`define CSF_CTRL_ENABLE   0
`define CSF_CTRL_LEVEL_LO 8
`define CSF_CTRL_LEVEL_HI 15
`define CSF_CTRL_RESET    32'h0000_0001

// ****************************************
// interrupt event bits
// ****************************************
`define CSF_EV_CHARGE     0
`define CSF_EV_FOREIGN    1
`define CSF_EV_FAULT      2
`define CSF_EV_COMPLETE   3
`define CSF_EV_REMOVED    4
`define CSF_EV_TIMEOUT    5
`define CSF_EV_WIDTH      6

// ****************************************
// timing
// ****************************************
`define CSF_CLK_HZ        20000000
`define CSF_INIT_MS       500
// counts are ms times clk_hz / 1000, the flash half period from half of CSF_BLINK_MS, sized to the 24-bit timers
`define CSF_INIT_CYCLES   24'h989680
`define CSF_BLINK_MS      1000
`define CSF_HALF_CYCLES   24'h989680
`define CSF_REQ_MS        100
`define CSF_REQ_CYCLES    24'h1e8480

`endif

// File: csf_rx_model.sv
// receiver model facing the charge session controller
// assumes: bench clock; place, mute, full and lvl come from the bench
`timescale 1ns/1ps

module csf_rx_model #(
  parameter [7:0] period = 8'h14
) (
  input  wire       clk,
  input  wire       place,
  input  wire       mute,
  input  wire       full,
  input  wire [7:0] lvl,
  input  wire       power_on,
  input  wire [7:0] power_level,
  output reg        rx_present = 1'h0,
  output reg        rx_identified = 1'h0,
  output reg        req_valid = 1'h0,
  output reg  [7:0] req_level = 8'h0,
  output reg        rx_done = 1'h0,
  output wire       power_match
);
  reg [7:0] tick = 8'h0;
  reg [7:0] last_lvl = 8'h0;

  assign power_match = !power_on || power_level == last_lvl;

  always @(posedge clk) begin
    rx_present    <= place;
    rx_identified <= place;
    rx_done       <= place && full;
    tick          <= (!place || tick == period) ? 8'h0 : tick + 8'h1;
    req_valid     <= place && !mute && tick == period;
    // between requests the level lines carry the inverse, not a held copy
    req_level     <= (place && !mute && tick == period) ? lvl : ~lvl;
    if (req_valid)
      last_lvl <= req_level;
  end
endmodule

// File: csf_session.v
// charge session controller with red and green status lamps
// Operation
// (R1) after reset, init state lights green lamp half a second, then off
// (R2) standby search keeps both lamps dark
// (R3) search for receiver, accept power request, then start transfer
// (R4) charging flashes green lamp once per second
// (R5) foreign object while charging aborts, red flashes until removal
// (R6) other fault aborts, red lamp steady until removal
// (R7) communication and over-voltage/current/power/temperature inputs are faults
// (R8) receiver done: complete state, green steady until removal
// (R9) receiver removal from any state returns to standby; the init state ignores removal and leaves only when its timer ends
// (R10) session ends when power requests stop arriving
// (R11) power only with receiver present, at requested level; the level is clamped to the ctrl level field
// (R12) delivered power must match request, none lost to foreign objects
// (R13) flashing uses one second period, equal on and off, clock counter
// assumes: all inputs synchronous to clk; avalon-mm master holds requests
`timescale 1ns/1ps
`include "csf_defs.vh"

module csf_session #(
  parameter [23:0] init_cycles = `CSF_INIT_CYCLES,
  parameter [23:0] half_cycles = `CSF_HALF_CYCLES,
  parameter [23:0] req_cycles  = `CSF_REQ_CYCLES
) (
  clk,
  reset_n,
  rx_present,
  rx_identified,
  req_valid,
  req_level,
  rx_done,
  foreign_obj,
  comm_err,
  over_volt,
  over_curr,
  over_power,
  over_temp,
  power_match,
  address,
  read,
  write,
  writedata,
  readdata,
  waitrequest,
  power_on,
  power_level,
  lamp_green,
  lamp_red,
  irq
);
  input  wire        clk;
  input  wire        reset_n;
  input  wire        rx_present;
  input  wire        rx_identified;
  input  wire        req_valid;
  input  wire [7:0]  req_level;
  input  wire        rx_done;
  input  wire        foreign_obj;
  input  wire        comm_err;
  input  wire        over_volt;
  input  wire        over_curr;
  input  wire        over_power;
  input  wire        over_temp;
  input  wire        power_match;
  input  wire [3:0]  address;
  input  wire        read;
  input  wire        write;
  input  wire [31:0] writedata;
  output reg  [31:0] readdata;
  output reg         waitrequest;
  output reg         power_on;
  output reg  [7:0]  power_level;
  output reg         lamp_green;
  output reg         lamp_red;
  output reg         irq;

  // ****************************************
  // states
  // ****************************************
  localparam [2:0] st_init     = 3'h0;
  localparam [2:0] st_standby  = 3'h1;
  localparam [2:0] st_config   = 3'h2;
  localparam [2:0] st_charge   = 3'h3;
  localparam [2:0] st_foreign  = 3'h4;
  localparam [2:0] st_fault    = 3'h5;
  localparam [2:0] st_complete = 3'h6;

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [23:0] timer;
  reg  [31:0] ctrl;
  reg  [`CSF_EV_WIDTH-1:0] irq_stat;
  reg  [`CSF_EV_WIDTH-1:0] irq_en;
  reg  [`CSF_EV_WIDTH-1:0] next_events;
  reg  [7:0]  granted;
  reg         bus_ack;
  reg         fault_any;
  reg         req_lost;
  wire        blink;
  wire        enabled;
  wire        bus_req;

  assign enabled = ctrl[`CSF_CTRL_ENABLE];
  assign bus_req = (read || write) && !bus_ack;

  // ****************************************
  // lamp flash timer
  // ****************************************
  csf_blink #(
    .half_cycles (half_cycles)
  ) u_blink (
    .clk     (clk),
    .reset_n (reset_n),
    .restart (state != next_state),
    .phase   (blink)
  );

  // ****************************************
  // fault and session loss detection
  // ****************************************
  always @* begin
    fault_any = comm_err || over_volt || over_curr ||
                over_power || over_temp; // R7
    if (state == st_charge && !power_match)
      fault_any = 1'b1; // R12
    req_lost = (state == st_charge || state == st_config) &&
               (timer >= req_cycles - 24'h000001); // R10
  end

  // ****************************************
  // session state machine
  // ****************************************
  always @* begin
    next_state  = state;
    next_events = {`CSF_EV_WIDTH{1'b0}};
    case (state)
      st_init: begin
        if (timer >= init_cycles - 24'h000001)
          next_state = st_standby; // R1
      end
      st_standby: begin
        if (enabled && rx_present && rx_identified)
          next_state = st_config; // R3
      end
      st_config: begin
        if (fault_any) begin
          next_state = st_fault;
          next_events[`CSF_EV_FAULT] = 1'b1;
        end else if (req_lost) begin
          next_state = st_standby;
          next_events[`CSF_EV_TIMEOUT] = 1'b1;
        end else if (req_valid) begin
          next_state = st_charge; // R3
          next_events[`CSF_EV_CHARGE] = 1'b1;
        end
      end
      st_charge: begin
        if (foreign_obj) begin
          next_state = st_foreign; // R5
          next_events[`CSF_EV_FOREIGN] = 1'b1;
        end else if (fault_any) begin
          next_state = st_fault; // R6
          next_events[`CSF_EV_FAULT] = 1'b1;
        end else if (rx_done) begin
          next_state = st_complete; // R8
          next_events[`CSF_EV_COMPLETE] = 1'b1;
        end else if (req_lost) begin
          next_state = st_standby; // R10
          next_events[`CSF_EV_TIMEOUT] = 1'b1;
        end
      end
      st_foreign: next_state = st_foreign;
      st_fault: next_state = st_fault;
      st_complete: next_state = st_complete;
      default: next_state = st_standby;
    endcase
    if (state != st_init && state != st_standby && !rx_present) begin
      next_state = st_standby; // R9
      next_events = {`CSF_EV_WIDTH{1'b0}};
      next_events[`CSF_EV_REMOVED] = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!reset_n) begin
      state <= st_init;
      timer <= 24'h000000;
    end else begin
      state <= next_state;
      if (next_state != state || (state == st_charge && req_valid))
        timer <= 24'h000000;
      else if (timer != 24'hffffff)
        timer <= timer + 24'h000001;
    end
  end

  // ****************************************
  // power stage command
  // ****************************************
  always @(posedge clk) begin
    if (!reset_n) begin
      power_on    <= 1'b0;
      power_level <= 8'h00;
      granted     <= 8'h00;
    end else begin
      if (next_state == st_charge && req_valid)
        granted <= (req_level < ctrl[`CSF_CTRL_LEVEL_HI:`CSF_CTRL_LEVEL_LO])
                   ? req_level : ctrl[`CSF_CTRL_LEVEL_HI:`CSF_CTRL_LEVEL_LO];
      power_on <= (next_state == st_charge) && rx_present; // R11
      if (next_state == st_charge && rx_present && req_valid)
        power_level <= (req_level <
                        ctrl[`CSF_CTRL_LEVEL_HI:`CSF_CTRL_LEVEL_LO])
                       ? req_level
                       : ctrl[`CSF_CTRL_LEVEL_HI:`CSF_CTRL_LEVEL_LO]; // R11
      else if (next_state == st_charge && rx_present)
        power_level <= granted;
      else
        power_level <= 8'h00;
    end
  end

  // ****************************************
  // lamps
  // ****************************************
  always @(posedge clk) begin
    if (!reset_n) begin
      lamp_green <= 1'b1;
      lamp_red   <= 1'b0;
    end else begin
      case (next_state)
        st_init: begin
          lamp_green <= 1'b1; // R1
          lamp_red   <= 1'b0;
        end
        st_charge: begin
          // a fresh session starts lit, not on a stale flash phase
          lamp_green <= blink | (state != st_charge); // R4
          lamp_red   <= 1'b0;
        end
        st_foreign: begin
          lamp_green <= 1'b0;
          lamp_red   <= blink | (state != st_foreign); // R5
        end
        st_fault: begin
          lamp_green <= 1'b0;
          lamp_red   <= 1'b1; // R6
        end
        st_complete: begin
          lamp_green <= 1'b1; // R8
          lamp_red   <= 1'b0;
        end
        default: begin
          lamp_green <= 1'b0; // R2
          lamp_red   <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // avalon-mm slave, one wait cycle per access
  // ****************************************
  always @(posedge clk) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      bus_ack     <= 1'b0;
      readdata    <= 32'h0000_0000;
      ctrl        <= `CSF_CTRL_RESET | 32'h0000_ff00;
      irq_en      <= {`CSF_EV_WIDTH{1'b0}};
      irq_stat    <= {`CSF_EV_WIDTH{1'b0}};
      irq         <= 1'b0;
    end else begin
      bus_ack     <= bus_req;
      waitrequest <= !bus_req;
      if (bus_req && write) begin
        case (address)
          `CSF_REG_CTRL:   ctrl   <= writedata & 32'h0000_ff01;
          `CSF_REG_IRQ_EN: irq_en <= writedata[`CSF_EV_WIDTH-1:0];
          default: ;
        endcase
      end
      // set wins over a clear in the same cycle
      if (bus_req && write && address == `CSF_REG_IRQ_STAT)
        irq_stat <= (irq_stat & ~writedata[`CSF_EV_WIDTH-1:0]) |
                    next_events;
      else
        irq_stat <= irq_stat | next_events;
      irq <= |((irq_stat | next_events) & irq_en);
      if (bus_req && read) begin
        case (address)
          `CSF_REG_CTRL:     readdata <= ctrl;
          `CSF_REG_STATUS:   readdata <= {16'h0000, power_level,
                                          2'h0, power_on, lamp_red,
                                          lamp_green, state};
          `CSF_REG_IRQ_STAT: readdata <= {26'h0, irq_stat};
          `CSF_REG_IRQ_EN:   readdata <= {26'h0, irq_en};
          default:           readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// File: csf_session_monitor.sv
// port checker for the charge session controller
// assumes: bound to csf_session, one clock, synchronous active-low reset
`timescale 1ns/1ps

module csf_session_monitor #(
  parameter [23:0] half_cycles = 24'h0a,
  parameter [23:0] req_cycles  = 24'h32
) (
  input wire       clk,
  input wire       reset_n,
  input wire       rx_present,
  input wire       rx_identified,
  input wire       req_valid,
  input wire [7:0] req_level,
  input wire       rx_done,
  input wire       foreign_obj,
  input wire       comm_err,
  input wire       over_volt,
  input wire       over_curr,
  input wire       over_power,
  input wire       over_temp,
  input wire       power_match,
  input wire       read,
  input wire       write,
  input wire       waitrequest,
  input wire       power_on,
  input wire [7:0] power_level,
  input wire       lamp_green,
  input wire       lamp_red
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  wire flt = comm_err | over_volt | over_curr | over_power | over_temp
             | !power_match;
  wire ok  = rx_present & !foreign_obj & !flt & !rx_done;
  reg [23:0] run;
  reg [23:0] gap;
  reg        last_g;

  // run: cycles green has held; gap: cycles since the last request
  always @(posedge clk) begin
    last_g <= lamp_green;
    run    <= (!reset_n || !power_on || lamp_green != last_g) ? 24'h0
              : run + 24'h1;
    gap    <= (!reset_n || !power_on || req_valid) ? 24'h0 : gap + 24'h1;
  end

  sequence s_init_lit;
    lamp_green [*8];
  endsequence
  sequence s_red_hold;
    lamp_red ##1 (lamp_red || !$past(rx_present)) [*4];
  endsequence

  chk_init_green: assert property ($rose(reset_n) |->
    s_init_lit ##[10:22] !lamp_green) else $error("init lamp wrong");
  chk_start_order: assert property ($rose(power_on) |->
    $past(req_valid) && $past(rx_identified)) else $error("early power");
  chk_level_follow: assert property (power_on && req_valid && ok |=>
    power_on && power_level == $past(req_level)) else $error("bad level");
  chk_foreign_abort: assert property (power_on && foreign_obj &&
    rx_present |=> !power_on && lamp_red && !lamp_green)
    else $error("foreign object not handled");
  chk_fault_red: assert property (power_on && flt && !foreign_obj &&
    rx_present |=> (!power_on && !lamp_green) ##0 s_red_hold)
    else $error("fault lamp wrong");
  chk_done_green: assert property (power_on && rx_done && !foreign_obj &&
    !flt && rx_present |=> !power_on && lamp_green && !lamp_red)
    else $error("complete lamp wrong");
  chk_remove_dark: assert property (!rx_present ##1 !rx_present |->
    !lamp_red && !power_on) else $error("not idle after removal");
  chk_blink_max: assert property (power_on |->
    run + 24'h1 <= half_cycles) else $error("green phase too long");
  chk_req_gap: assert property (power_on |->
    gap <= req_cycles + 24'h2) else $error("no request timeout");
  chk_bus_answer: assert property ($rose(read || write) |=>
    !waitrequest ##1 waitrequest) else $error("bus answer late");
endmodule

bind csf_session csf_session_monitor #(.half_cycles(half_cycles),
  .req_cycles(req_cycles)) u_mon (.clk(clk), .reset_n(reset_n),
  .rx_present(rx_present), .rx_identified(rx_identified),
  .req_valid(req_valid), .req_level(req_level), .rx_done(rx_done),
  .foreign_obj(foreign_obj), .comm_err(comm_err), .over_volt(over_volt),
  .over_curr(over_curr), .over_power(over_power), .over_temp(over_temp),
  .power_match(power_match), .read(read), .write(write),
  .waitrequest(waitrequest), .power_on(power_on),
  .power_level(power_level), .lamp_green(lamp_green),
  .lamp_red(lamp_red));

// File: csf_session_tb.sv
// self-checking bench for the charge session controller
// assumes: csf_session with short counts, receiver model, monitor bound
`timescale 1ns/1ps
`include "csf_defs.vh"

module csf_session_tb;
  reg          clk;
  reg          reset_n;
  reg          place;
  reg          mute;
  reg          full;
  reg          foreign_obj;
  reg  [4:0]   flt;
  reg  [7:0]   lvl;
  reg  [3:0]   address;
  reg          read;
  reg          write;
  reg  [31:0]  writedata;
  reg  [31:0]  q;
  wire         rx_present, rx_identified, req_valid, rx_done, power_match;
  wire         waitrequest, power_on, lamp_green, lamp_red, irq;
  wire [7:0]   req_level, power_level;
  wire [31:0]  readdata;
  integer      n_fail, checks, k, s;

  csf_session #(.init_cycles(24'h14), .half_cycles(24'h0a),
    .req_cycles(24'h32)) dut (.clk, .reset_n, .rx_present, .rx_identified,
    .req_valid, .req_level, .rx_done, .foreign_obj, .comm_err(flt[0]),
    .over_volt(flt[1]), .over_curr(flt[2]), .over_power(flt[3]),
    .over_temp(flt[4]), .power_match, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .power_on, .power_level, .lamp_green,
    .lamp_red, .irq);
  csf_rx_model rx (.clk, .place, .mute, .full, .lvl, .power_on,
    .power_level, .rx_present, .rx_identified, .req_valid, .req_level,
    .rx_done, .power_match);

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // ****************************************
  // access and check tasks
  // ****************************************
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      read <= !w;
      write <= w;
      address <= a;
      writedata <= d;
      @(posedge clk);
      while (waitrequest !== 1'h0)
        @(posedge clk);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
      @(posedge clk);
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("FAIL %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task up;
    begin
      place <= 1'h1;
      s = 0;
      while (power_on !== 1'h1 && s < 100) begin
        @(posedge clk);
        s = s + 1;
      end
      chk("start", 32'h3, {lamp_green, power_on});
    end
  endtask
  // sum of red (sel 1) or green lamp over twenty cycles
  task duty(input sel);
    begin
      s = 0;
      repeat (20) begin
        @(posedge clk);
        s = s + (sel ? lamp_red : lamp_green);
      end
    end
  endtask
  task off;
    begin
      place <= 1'h0;
      cyc(3);
      chk("lamps", 32'h0, {lamp_red, lamp_green, power_on});
      cyc(3);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  initial begin
    cyc(5000);
    n_fail = n_fail + 1;
    conclude;
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {n_fail, checks, reset_n, place, mute, full, foreign_obj} = 0;
    {flt, address, read, write, writedata} = 0;
    lvl = 8'h40;
    cyc(16);
    reset_n <= 1'h1;
    cyc(1);
    chk("lamps", 32'h2, {lamp_red, lamp_green, power_on});
    bus(1'h0, `CSF_REG_CTRL, 32'h0);
    chk("ctrl", 32'h0000ff01, q);
    bus(1'h0, `CSF_REG_STATUS, 32'h0);
    chk("status", 32'h8, q);
    bus(1'h0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'h1, `CSF_REG_IRQ_EN, 32'h3f);
    cyc(25);
    bus(1'h0, `CSF_REG_STATUS, 32'h0);
    chk("status", 32'h1, q);
    $display("test init done");
    up;
    chk("level", 32'h40, power_level);
    chk("irq", 32'h1, irq);
    bus(1'h1, `CSF_REG_IRQ_STAT, 32'h1);
    cyc(2);
    chk("irq", 32'h0, irq);
    duty(1'h0);
    chk("green duty", 32'ha, s);
    lvl <= 8'h20;
    cyc(45);
    chk("level", 32'h20, power_level);
    full <= 1'h1;
    cyc(2);
    duty(1'h0);
    chk("green steady", 32'h14, s);
    full <= 1'h0;
    off;
    bus(1'h0, `CSF_REG_IRQ_STAT, 32'h0);
    chk("irq stat", 32'h18, q);
    bus(1'h1, `CSF_REG_IRQ_STAT, 32'h3f);
    $display("test charge done");
    up;
    foreign_obj <= 1'h1;
    cyc(2);
    foreign_obj <= 1'h0;
    chk("lamps", 32'h4, {lamp_red, lamp_green, power_on});
    duty(1'h1);
    chk("red duty", 32'ha, s);
    off;
    for (k = 0; k < 5; k = k + 1) begin
      up;
      flt[k] <= 1'h1;
      cyc(2);
      flt <= 5'h0;
      chk("power", 32'h0, power_on);
      duty(1'h1);
      chk("red steady", 32'h14, s);
      off;
    end
    // cap below the request: delivered power no longer matches
    bus(1'h1, `CSF_REG_CTRL, 32'h00001001);
    up;
    cyc(2);
    chk("lamps", 32'h4, {lamp_red, lamp_green, power_on});
    off;
    bus(1'h1, `CSF_REG_CTRL, 32'h0000ff01);
    $display("test faults done");
    bus(1'h1, `CSF_REG_IRQ_EN, 32'h0);
    up;
    mute <= 1'h1;
    cyc(60);
    chk("power", 32'h0, power_on);
    chk("irq", 32'h0, irq);
    bus(1'h0, `CSF_REG_IRQ_STAT, 32'h0);
    chk("timeout event", 32'h1, q[5]);
    mute <= 1'h0;
    off;
    bus(1'h1, `CSF_REG_CTRL, 32'h0000ff00);
    place <= 1'h1;
    cyc(60);
    chk("power", 32'h0, power_on);
    off;
    $display("test timeout done");
    conclude;
  end
endmodule
